//--- shared/pie_pkg.sv
// Package for the peripheral interrupt enable and priority block
package pie_pkg;
    // Register indexes on the plain register port
    localparam logic [3:0] ADDR_EN1 = 4'h0;
    localparam logic [3:0] ADDR_EN2 = 4'h1;
    localparam logic [3:0] ADDR_EN3 = 4'h2;
    localparam logic [3:0] ADDR_PR1 = 4'h3;
    localparam logic [3:0] ADDR_PR2 = 4'h4;
    localparam logic [3:0] ADDR_PR3 = 4'h5;
    localparam logic [3:0] ADDR_RCTL = 4'h6;
    localparam logic [3:0] ADDR_FLAG1 = 4'h7;
    localparam logic [3:0] ADDR_FLAG2 = 4'h8;
    localparam logic [3:0] ADDR_FLAG3 = 4'h9;
    // Reset values
    localparam logic [7:0] EN_RESET = 8'h00;
    localparam logic [7:0] PR_RESET = 8'hff;
    localparam logic [7:0] PR2_RESET = 8'hfb;
    // Writable masks
    localparam logic [7:0] EN2_WMASK = 8'hfb;
    localparam logic [7:0] PR2_WMASK = 8'hfb;
    localparam logic [7:0] EN3_WMASK = 8'hcf;
    // Package variant gating: bit 7 of set 1, bits 7:6 and 5:4 of set 3
    localparam logic [7:0] SET1_PSP_MASK = 8'h80;
    localparam logic [7:0] SET3_BIG_MASK = 8'hc0;
    localparam logic [7:0] SET3_MID_MASK = 8'h30;
    // Reset control register field positions
    localparam int RCTL_PRIO_EN_BIT = 7;
    localparam logic [7:0] RCTL_WMASK = 8'h80;
    // Package variants
    localparam logic [1:0] PKG_SMALL = 2'h0;
    localparam logic [1:0] PKG_MID = 2'h1;
    localparam logic [1:0] PKG_BIG = 2'h2;

    typedef struct packed {
        logic [7:0] set1;
        logic [7:0] set2;
        logic [7:0] set3;
    } pie_src_t;

    typedef struct packed {
        logic high_req;
        logic low_req;
    } pie_req_t;
endpackage

//--- logic/pie_irq_ctrl.sv
// Peripheral interrupt enable and priority registers with request gating
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ps
// ==========================================================
module pie_irq_ctrl
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire pie_pkg::pie_src_t src_flags,
    input wire logic [1:0] pkg_variant,
    input wire logic mcu_mode,
    input wire logic global_peripheral_irq_en,
    input wire logic [4:0] reset_cause,
    output logic priority_levels_enable,
    output logic irq_high,
    output logic irq_low
);

    // ==========================================================
    // Register state
    logic [7:0] peripheral_enable_one;
    logic [7:0] peripheral_enable_two;
    logic [7:0] peripheral_enable_three;
    logic [7:0] peripheral_priority_one;
    logic [7:0] peripheral_priority_two;
    logic [7:0] peripheral_priority_three;
    logic prio_en;
    logic [7:0] rdata;
    logic high_q;
    logic low_q;
    logic [7:0] next_en1;
    logic [7:0] next_en2;
    logic [7:0] next_en3;
    logic [7:0] next_pr1;
    logic [7:0] next_pr2;
    logic [7:0] next_pr3;
    logic next_prio_en;
    logic [7:0] next_rdata;
    logic next_high;
    logic next_low;
    pie_pkg::pie_src_t impl;
    pie_pkg::pie_src_t en_all;
    pie_pkg::pie_src_t pr_all;
    logic [9:0] wr_sel;
    logic [9:0] rd_sel;
    logic [23:0] lane_live;
    logic [23:0] lane_high;
    logic [23:0] lane_low;

    // Variant straps are static, so no synchroniser stage is used
    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
                                         input logic [7:0] mask);
        merge = (old & ~mask) | (wd & mask);
    endfunction

    // Index decode shared by the write and read paths, so that both agree
    // on which indexes are mapped
    function automatic logic [9:0] reg_select(input logic [3:0] addr);
        reg_select = 10'h000;
        unique case (addr)
            pie_pkg::ADDR_EN1: reg_select[pie_pkg::ADDR_EN1] = 1'b1;
            pie_pkg::ADDR_EN2: reg_select[pie_pkg::ADDR_EN2] = 1'b1;
            pie_pkg::ADDR_EN3: reg_select[pie_pkg::ADDR_EN3] = 1'b1;
            pie_pkg::ADDR_PR1: reg_select[pie_pkg::ADDR_PR1] = 1'b1;
            pie_pkg::ADDR_PR2: reg_select[pie_pkg::ADDR_PR2] = 1'b1;
            pie_pkg::ADDR_PR3: reg_select[pie_pkg::ADDR_PR3] = 1'b1;
            pie_pkg::ADDR_RCTL: reg_select[pie_pkg::ADDR_RCTL] = 1'b1;
            pie_pkg::ADDR_FLAG1: reg_select[pie_pkg::ADDR_FLAG1] = 1'b1;
            pie_pkg::ADDR_FLAG2: reg_select[pie_pkg::ADDR_FLAG2] = 1'b1;
            pie_pkg::ADDR_FLAG3: reg_select[pie_pkg::ADDR_FLAG3] = 1'b1;
            default: reg_select = 10'h000;
        endcase
    endfunction

    // ==========================================================
    // Implemented bits per package variant
    always_comb
    begin
        impl.set1 = 8'hff;
        impl.set2 = pie_pkg::EN2_WMASK;
        impl.set3 = 8'hff;
        if (!(pkg_variant == pie_pkg::PKG_BIG && mcu_mode))
        begin
            impl.set1 = impl.set1 & ~pie_pkg::SET1_PSP_MASK;
        end
        if (pkg_variant != pie_pkg::PKG_BIG)
        begin
            impl.set3 = impl.set3 & ~pie_pkg::SET3_BIG_MASK;
        end
        if (pkg_variant == pie_pkg::PKG_SMALL)
        begin
            impl.set3 = impl.set3 & ~pie_pkg::SET3_MID_MASK;
        end
    end

    // ==========================================================
    // Strobe qualified register selects
    always_comb
    begin
        wr_sel = 10'h000;
        rd_sel = 10'h000;
        if (reg_wr)
        begin
            wr_sel = reg_select(reg_addr);
        end
        if (reg_rd)
        begin
            rd_sel = reg_select(reg_addr);
        end
    end

    // ==========================================================
    // Enable registers
    always_comb
    begin
        next_en1 = peripheral_enable_one;
        next_en2 = peripheral_enable_two;
        next_en3 = peripheral_enable_three;
        if (wr_sel[pie_pkg::ADDR_EN1])
        begin
            next_en1 = merge(peripheral_enable_one, reg_wdata, impl.set1);
        end
        if (wr_sel[pie_pkg::ADDR_EN2])
        begin
            next_en2 = merge(peripheral_enable_two, reg_wdata, impl.set2);
        end
        if (wr_sel[pie_pkg::ADDR_EN3])
        begin
            // Serial port two enables stay zero whatever software writes
            next_en3 = merge(peripheral_enable_three, reg_wdata,
                             impl.set3 & pie_pkg::EN3_WMASK);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            peripheral_enable_one <= pie_pkg::EN_RESET;
            peripheral_enable_two <= pie_pkg::EN_RESET;
            peripheral_enable_three <= pie_pkg::EN_RESET;
        end
        else
        begin
            peripheral_enable_one <= next_en1;
            peripheral_enable_two <= next_en2;
            peripheral_enable_three <= next_en3;
        end
    end

    // ==========================================================
    // Priority registers
    always_comb
    begin
        next_pr1 = peripheral_priority_one;
        next_pr2 = peripheral_priority_two;
        next_pr3 = peripheral_priority_three;
        if (wr_sel[pie_pkg::ADDR_PR1])
        begin
            next_pr1 = merge(peripheral_priority_one, reg_wdata, impl.set1);
        end
        if (wr_sel[pie_pkg::ADDR_PR2])
        begin
            // Reserved bit 4 stays writable; keeping it set is up to software
            next_pr2 = merge(peripheral_priority_two, reg_wdata, pie_pkg::PR2_WMASK);
        end
        if (wr_sel[pie_pkg::ADDR_PR3])
        begin
            next_pr3 = merge(peripheral_priority_three, reg_wdata, impl.set3);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            peripheral_priority_one <= pie_pkg::PR_RESET;
            peripheral_priority_two <= pie_pkg::PR2_RESET;
            peripheral_priority_three <= pie_pkg::PR_RESET;
        end
        else
        begin
            peripheral_priority_one <= next_pr1;
            peripheral_priority_two <= next_pr2;
            peripheral_priority_three <= next_pr3;
        end
    end

    // ==========================================================
    // Priority level control
    always_comb
    begin
        next_prio_en = prio_en;
        if (wr_sel[pie_pkg::ADDR_RCTL])
        begin
            next_prio_en = reg_wdata[pie_pkg::RCTL_PRIO_EN_BIT];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            prio_en <= 1'b0;
        end
        else
        begin
            prio_en <= next_prio_en;
        end
    end

    // ==========================================================
    // Read data, valid for the one cycle after the read strobe
    always_comb
    begin
        next_rdata = 8'h00;
        unique case (1'b1)
            rd_sel[pie_pkg::ADDR_EN1]: next_rdata = peripheral_enable_one & impl.set1;
            rd_sel[pie_pkg::ADDR_EN2]: next_rdata = peripheral_enable_two & impl.set2;
            rd_sel[pie_pkg::ADDR_EN3]: next_rdata = peripheral_enable_three & impl.set3;
            rd_sel[pie_pkg::ADDR_PR1]: next_rdata = peripheral_priority_one & impl.set1;
            rd_sel[pie_pkg::ADDR_PR2]: next_rdata = peripheral_priority_two & impl.set2;
            rd_sel[pie_pkg::ADDR_PR3]: next_rdata = peripheral_priority_three & impl.set3;
            rd_sel[pie_pkg::ADDR_RCTL]: next_rdata = {prio_en, 2'b00, reset_cause};
            rd_sel[pie_pkg::ADDR_FLAG1]: next_rdata = src_flags.set1 & impl.set1;
            rd_sel[pie_pkg::ADDR_FLAG2]: next_rdata = src_flags.set2 & impl.set2;
            rd_sel[pie_pkg::ADDR_FLAG3]: next_rdata = src_flags.set3 & impl.set3;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            rdata <= 8'h00;
        end
        else
        begin
            rdata <= next_rdata;
        end
    end

    // ==========================================================
    // Per-source request lanes and level routing
    always_comb
    begin
        en_all = {peripheral_enable_one, peripheral_enable_two, peripheral_enable_three};
        pr_all = {peripheral_priority_one, peripheral_priority_two,
                  peripheral_priority_three};
    end

    for (genvar lane = 0; lane < $bits(pie_pkg::pie_src_t); lane++)
    begin : g_lane
        // An absent source never requests, even if its flag input is high
        assign lane_live[lane] = src_flags[lane] & en_all[lane] & impl[lane];
        assign lane_high[lane] = lane_live[lane] & pr_all[lane];
        assign lane_low[lane] = lane_live[lane] & ~pr_all[lane];
    end

    always_comb
    begin
        next_high = 1'b0;
        next_low = 1'b0;
        if (prio_en)
        begin
            next_high = |lane_high;
            next_low = |lane_low;
        end
        else
        begin
            // Single-level mode reports everything on the high line, behind the global gate
            next_high = (|lane_live) && global_peripheral_irq_en;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            high_q <= 1'b0;
            low_q <= 1'b0;
        end
        else
        begin
            high_q <= next_high;
            low_q <= next_low;
        end
    end

    assign reg_rdata = rdata;
    assign priority_levels_enable = prio_en;
    assign irq_high = high_q;
    assign irq_low = low_q;

endmodule

//--- dv/pie_irq_ctrl_monitor.sv
// Port checker for the interrupt enable and priority block
`timescale 1ns/1ps
module pie_irq_ctrl_monitor
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire pie_pkg::pie_src_t src_flags,
    input wire logic global_peripheral_irq_en,
    input wire logic [4:0] reset_cause,
    input wire logic priority_levels_enable,
    input wire logic irq_high,
    input wire logic irq_low
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // ========
    // Register reads
    sequence s_rd(logic [3:0] a);
        reg_rd && reg_addr == a;
    endsequence
    a_rdata_idle:
        assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("Stray read data");
    a_unmapped_read:
        assert property (reg_rd && reg_addr > 4'h9 |=> reg_rdata == 8'h00) else $error("Unmapped");
    a_rctl_read:
        assert property (s_rd(pie_pkg::ADDR_RCTL) |=> reg_rdata ==
            {$past(priority_levels_enable), 2'b00, $past(reset_cause)}) else $error("Rctl read");
    a_bit2_zero:
        assert property (s_rd(pie_pkg::ADDR_EN2) or s_rd(pie_pkg::ADDR_PR2) |=> !reg_rdata[2])
        else $error("Bit 2 set");
    a_en3_readonly:
        assert property (s_rd(pie_pkg::ADDR_EN3) |=> reg_rdata[5:4] == 2'b00) else $error("En3");
    // ========
    // Requests
    a_reset_quiet:
        assert property ($rose(nrst) |-> !irq_high && !irq_low && !priority_levels_enable)
        else $error("Not reset");
    a_prio_write:
        assert property (reg_wr && reg_addr == pie_pkg::ADDR_RCTL && reg_wdata[7]
            |=> priority_levels_enable) else $error("Prio enable lost");
    a_low_gated:
        assert property (!$past(priority_levels_enable) |-> !irq_low) else $error("Low in compat");
    a_compat_gate:
        assert property (!$past(priority_levels_enable) && !$past(global_peripheral_irq_en)
            |-> !irq_high) else $error("High not gated");
    a_no_flags:
        assert property ($past(src_flags) == 24'h0 |-> !irq_high && !irq_low)
        else $error("Request without flag");
endmodule

//--- dv/pie_flag_src.sv
// Flag source model standing in for the peripherals
`timescale 1ns/1ps
module pie_flag_src
(
    input wire logic ref_clk,
    input wire pie_pkg::pie_src_t flag_cmd,
    output pie_pkg::pie_src_t src_flags = 24'h0
);
    // Flags rise a clock after the event, as from a peripheral's own register
    always_ff @(posedge ref_clk)
        src_flags <= flag_cmd;
endmodule

//--- dv/pie_irq_ctrl_tb.sv
// Self-checking bench for the interrupt enable and priority block
`timescale 1ns/1ps
module pie_irq_ctrl_tb;
    logic ref_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, mcu_mode = 1'b1;
    logic global_peripheral_irq_en = 1'b0, priority_levels_enable, irq_high, irq_low;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic [1:0] pkg_variant = pie_pkg::PKG_BIG;
    logic [4:0] reset_cause = 5'h15;
    pie_pkg::pie_src_t flag_cmd = 24'h0, src_flags;
    int n_errors = 0, checks_done = 0;
    initial forever #12.5 ref_clk = ~ref_clk;
    pie_flag_src src_u (.ref_clk(ref_clk), .flag_cmd(flag_cmd), .src_flags(src_flags));
    pie_irq_ctrl dut_u (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .src_flags(src_flags), .pkg_variant(pkg_variant), .mcu_mode(mcu_mode),
        .global_peripheral_irq_en(global_peripheral_irq_en), .reset_cause(reset_cause),
        .priority_levels_enable(priority_levels_enable), .irq_high(irq_high), .irq_low(irq_low));
    // ========
    // Bus and compare tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    // Requests lag flags by the model's register plus the block's own
    task automatic irq(input logic [1:0] e);
        repeat (3) @(posedge ref_clk);
        #1 chk({6'h0, irq_high, irq_low}, {6'h0, e});
    endtask
    task automatic do_reset(input logic [1:0] v);
        @(posedge ref_clk);
        {nrst, pkg_variant} <= {1'b0, v};
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
    endtask
    task automatic give_verdict();
        $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ========
    // Scenarios
    task automatic t_rst();
        rd(pie_pkg::ADDR_EN2, 8'h00);
        rd(pie_pkg::ADDR_EN3, 8'h00);
        rd(pie_pkg::ADDR_PR1, 8'hff);
        rd(pie_pkg::ADDR_PR2, 8'hfb);
        rd(pie_pkg::ADDR_PR3, 8'hff);
        rd(pie_pkg::ADDR_RCTL, {3'h0, reset_cause});
        $display("reset values done");
    endtask
    task automatic t_mask();
        wr(pie_pkg::ADDR_EN2, 8'hef);
        rd(pie_pkg::ADDR_EN2, 8'heb);
        wr(pie_pkg::ADDR_EN3, 8'hff);
        rd(pie_pkg::ADDR_EN3, 8'hcf);
        wr(pie_pkg::ADDR_PR2, 8'h14);
        rd(pie_pkg::ADDR_PR2, 8'h10);
        wr(pie_pkg::ADDR_PR3, 8'h0f);
        rd(pie_pkg::ADDR_PR3, 8'h0f);
        wr(4'hf, 8'hff);
        rd(4'hf, 8'h00);
        $display("register masks done");
    endtask
    task automatic t_route();
        wr(pie_pkg::ADDR_RCTL, 8'h80);
        flag_cmd <= 24'h800110;
        rd(pie_pkg::ADDR_RCTL, {3'h4, reset_cause});
        chk({7'h0, priority_levels_enable}, 8'h01);
        wr(pie_pkg::ADDR_EN2, 8'h01);
        irq(2'b01);
        rd(pie_pkg::ADDR_FLAG1, 8'h80);
        rd(pie_pkg::ADDR_FLAG2, 8'h01);
        rd(pie_pkg::ADDR_FLAG3, 8'h10);
        wr(pie_pkg::ADDR_PR2, 8'h11);
        irq(2'b10);
        wr(pie_pkg::ADDR_EN2, 8'h00);
        irq(2'b00);
        wr(pie_pkg::ADDR_EN1, 8'h80);
        irq(2'b10);
        rd(pie_pkg::ADDR_EN1, 8'h80);
        wr(pie_pkg::ADDR_PR1, 8'h00);
        irq(2'b01);
        $display("routing done");
    endtask
    task automatic t_compat();
        wr(pie_pkg::ADDR_RCTL, 8'h00);
        irq(2'b00);
        chk({7'h0, priority_levels_enable}, 8'h00);
        @(posedge ref_clk);
        global_peripheral_irq_en <= 1'b1;
        irq(2'b10);
        $display("single level done");
    endtask
    // Absent sources read zero on smaller packages and outside microcontroller mode
    task automatic t_pkg();
        @(posedge ref_clk);
        mcu_mode <= 1'b0;
        for (int v = 0; v < 3; v++)
        begin
            do_reset(2'(v));
            rd(pie_pkg::ADDR_PR1, 8'h7f);
            rd(pie_pkg::ADDR_PR3, {{2{v == 2}}, {2{v > 0}}, 4'hf});
        end
        $display("package variants done");
    endtask
    initial
    begin
        do_reset(pie_pkg::PKG_BIG);
        t_rst();
        t_mask();
        t_route();
        t_compat();
        t_pkg();
        give_verdict();
    end
    initial
    begin
        repeat (3000) @(posedge ref_clk);
        n_errors++;
        give_verdict();
    end
endmodule

bind pie_irq_ctrl pie_irq_ctrl_monitor mon_u (.ref_clk(ref_clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .src_flags(src_flags), .reset_cause(reset_cause),
    .global_peripheral_irq_en(global_peripheral_irq_en), .irq_high(irq_high),
    .priority_levels_enable(priority_levels_enable), .irq_low(irq_low));
